// ==== hdl/mpr_cmd_core.v ====
// Purpose: command interpreter for reset, low-power standby, timing and rf on/off
// Assumes: rxData/rxValid come from a uart on core_clk; responses go to a uart encoder
// Notes:   config writes land in staging copies and take effect on the reset command
//
// Function
// - normal end for the reset command answered within 520 ms
// - reset commits staged registers and discards temporary address and frequency values
// - reset during the line test ends it and drops staged settings
// - serial settings switch at reset so the answer uses them
// - standby release leaves low power with normal end, errors if not in standby
// - standby entry enters low power with normal end, errors if already there
// - extended standby setting takes 000 to 015, query returns three digits
// - extended standby lasts setting times 20 ms, zero disables it
// - no extended standby after broadcast or with group address check off
// - standby time 001 to 255 times 10 ms with rf kept on
// - sleep time 001 to 255 times 10 ms or 100 ms by base bit
// - timing commands query, store with normal end, or answer command error
// - rf off powers rf down with normal end, errors when already off
// - text and binary transmit refused while rf is off
// - commands end in carriage return then line feed, anything else errors
`include "mpr_defs.vh"

module mpr_cmd_core #(
   parameter TICK10_CYCLES  = `MPR_TICK_MS * `MPR_CLK_KHZ,
   parameter RSP_MAX_CYCLES = `MPR_RSP_MAX_MS * `MPR_CLK_KHZ
) (
   input  wire        core_clk,
   input  wire        sys_rst,
   input  wire [7:0]  rxData,
   input  wire        rxValid,
   input  wire [1:0]  regAddr,
   input  wire [7:0]  regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [7:0]  regRdData,
   input  wire        nvmAck,
   input  wire        lqtActive,
   input  wire        lastTxBroadcast,
   output reg         respValid,
   output reg  [1:0]  respCode,
   output reg  [7:0]  respValue,
   output reg         txFwdValid,
   output reg         txFwdBinary,
   output reg         regApply,
   output reg         nvmStore,
   output reg         tempDiscard,
   output reg         lqtAbort,
   output reg  [7:0]  serialCfg,
   output reg         rfPower,
   output reg         lowPower,
   output reg  [1:0]  stbyPhase
);

   // parser states
   localparam [1:0] P_IDLE = 2'h0;
   localparam [1:0] P_NAME = 2'h1;
   localparam [1:0] P_ARG  = 2'h2;
   localparam [1:0] P_LF   = 2'h3;
   // standby sequence phases
   localparam [1:0] S_OFF   = 2'h0;
   localparam [1:0] S_STBY  = 2'h1;
   localparam [1:0] S_EXT   = 2'h2;
   localparam [1:0] S_SLEEP = 2'h3;

   // integer sums cut to the counter widths on purpose
   localparam integer           TICK_LAST_I = TICK10_CYCLES - 1;
   localparam integer           RSP_LAST_I  = RSP_MAX_CYCLES - 2;
   localparam [`MPR_TICK_W-1:0] TICK_LAST   = TICK_LAST_I[`MPR_TICK_W-1:0];
   localparam [`MPR_RSP_W-1:0]  RSP_LAST    = RSP_LAST_I[`MPR_RSP_W-1:0];

   // ==================================================================
   // time base
   reg [`MPR_TICK_W-1:0] tickCnt_q;
   reg [3:0]             decCnt_q;
   reg                   half_q;
   reg                   tick10_q;
   reg                   tick20_q;
   reg                   tick100_q;

   // free-running so all intervals share one phase; first unit may be short
   always @(posedge core_clk) begin
      if (sys_rst) begin
         tickCnt_q <= {`MPR_TICK_W{1'b0}};
         decCnt_q  <= 4'h0;
         half_q    <= 1'b0;
         tick10_q  <= 1'b0;
         tick20_q  <= 1'b0;
         tick100_q <= 1'b0;
      end else begin
         tick10_q  <= 1'b0;
         tick20_q  <= 1'b0;
         tick100_q <= 1'b0;
         if (tickCnt_q == TICK_LAST) begin
            tickCnt_q <= {`MPR_TICK_W{1'b0}};
            tick10_q  <= 1'b1;
            half_q    <= ~half_q;
            tick20_q  <= half_q;
            if (decCnt_q == `MPR_DEC_LAST) begin
               decCnt_q  <= 4'h0;
               tick100_q <= 1'b1;
            end else begin
               decCnt_q <= decCnt_q + 4'h1;
            end
         end else begin
            tickCnt_q <= tickCnt_q + {{(`MPR_TICK_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ==================================================================
   // register port: staged copies and committed copies
   reg [7:0] sleepStage_q;
   reg [7:0] achkStage_q;
   reg [7:0] serStage_q;
   reg [7:0] sleepCfg_q;
   reg [7:0] achkCfg_q;
   reg       busy_q;
   reg       commit_q;
   reg       restore_q;

   // staging writes wait for reset; restore wins over a write in the same cycle
   always @(posedge core_clk) begin
      if (sys_rst) begin
         sleepStage_q <= `MPR_SLEEP_CFG_RST;
         achkStage_q  <= `MPR_ACHK_CFG_RST;
         serStage_q   <= `MPR_SER_CFG_RST;
         sleepCfg_q   <= `MPR_SLEEP_CFG_RST;
         achkCfg_q    <= `MPR_ACHK_CFG_RST;
         serialCfg    <= `MPR_SER_CFG_RST;
      end else if (restore_q) begin
         sleepStage_q <= sleepCfg_q;
         achkStage_q  <= achkCfg_q;
         serStage_q   <= serialCfg;
      end else if (commit_q) begin
         sleepCfg_q <= sleepStage_q;
         achkCfg_q  <= achkStage_q;
         serialCfg  <= serStage_q;
      end else if (regWr) begin
         case (regAddr)
            `MPR_ADR_SLEEP_CFG: sleepStage_q <= regWrData;
            `MPR_ADR_ACHK_CFG:  achkStage_q  <= regWrData;
            `MPR_ADR_SER_CFG:   serStage_q   <= regWrData;
            default:            ;
         endcase
      end
   end

   // read data one cycle after the strobe; status is read-only
   always @(posedge core_clk) begin
      if (sys_rst) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            `MPR_ADR_SLEEP_CFG: regRdData <= sleepStage_q;
            `MPR_ADR_ACHK_CFG:  regRdData <= achkStage_q;
            `MPR_ADR_SER_CFG:   regRdData <= serStage_q;
            default:            regRdData <= {3'h0, busy_q, stbyPhase, lowPower, rfPower};
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   // ==================================================================
   // byte parser: '@', three letters, optional digits, cr, lf
   reg [1:0]  pState_q;
   reg [23:0] name_q;
   reg [1:0]  nameCnt_q;
   reg [9:0]  argVal_q;
   reg [1:0]  argCnt_q;
   reg        argBad_q;
   reg        go_q;
   reg        frameErr_q;
   wire       isDigit = (rxData >= `MPR_CH_D0) && (rxData <= `MPR_CH_D9);
   wire [9:0] argNext = {argVal_q[6:0], 3'h0} + {argVal_q[8:0], 1'b0} + {6'h00, rxData[3:0]};

   // bytes arriving while a reset commit is busy are dropped
   always @(posedge core_clk) begin
      if (sys_rst) begin
         pState_q   <= P_IDLE;
         name_q     <= 24'h000000;
         nameCnt_q  <= 2'h0;
         argVal_q   <= 10'h000;
         argCnt_q   <= 2'h0;
         argBad_q   <= 1'b0;
         go_q       <= 1'b0;
         frameErr_q <= 1'b0;
      end else begin
         go_q       <= 1'b0;
         frameErr_q <= 1'b0;
         if (rxValid && !busy_q) begin
            case (pState_q)
               P_IDLE: begin
                  if (rxData == `MPR_CH_AT) begin
                     pState_q  <= P_NAME;
                     nameCnt_q <= 2'h0;
                     argVal_q  <= 10'h000;
                     argCnt_q  <= 2'h0;
                     argBad_q  <= 1'b0;
                  end
               end
               P_NAME: begin
                  name_q    <= {name_q[15:0], rxData};
                  nameCnt_q <= nameCnt_q + 2'h1;
                  if (nameCnt_q == 2'h2) begin
                     pState_q <= P_ARG;
                  end
               end
               P_ARG: begin
                  if (rxData == `MPR_CH_CR) begin
                     pState_q <= P_LF;
                  end else if (rxData == `MPR_CH_LF) begin
                     pState_q   <= P_IDLE;
                     frameErr_q <= 1'b1;
                  end else if (isDigit && (argCnt_q != `MPR_ARG_DIGITS)) begin
                     argVal_q <= argNext;
                     argCnt_q <= argCnt_q + 2'h1;
                  end else begin
                     argBad_q <= 1'b1;
                  end
               end
               P_LF: begin
                  pState_q <= P_IDLE;
                  if (rxData == `MPR_CH_LF) begin
                     go_q <= 1'b1;
                  end else begin
                     frameErr_q <= 1'b1;
                  end
               end
               default: pState_q <= P_IDLE;
            endcase
         end
      end
   end

   // ==================================================================
   // command execution and responses
   reg [7:0]            extTime_q;
   reg [7:0]            stbyTime_q;
   reg [7:0]            sleepTime_q;
   reg                  rfOn_q;
   reg [`MPR_RSP_W-1:0] rspCnt_q;
   wire                 noArg  = (argCnt_q == 2'h0) && !argBad_q;
   wire                 setArg = (argCnt_q == `MPR_ARG_DIGITS) && !argBad_q;
   wire                 timeOk = (argVal_q >= `MPR_TIME_MIN) && (argVal_q <= `MPR_TIME_MAX);

   always @(posedge core_clk) begin
      if (sys_rst) begin
         extTime_q   <= `MPR_EXT_RST;
         stbyTime_q  <= `MPR_STBY_RST;
         sleepTime_q <= `MPR_SLEEP_RST;
         rfOn_q      <= 1'b1;
         lowPower    <= 1'b0;
         busy_q      <= 1'b0;
         rspCnt_q    <= {`MPR_RSP_W{1'b0}};
         commit_q    <= 1'b0;
         restore_q   <= 1'b0;
         respValid   <= 1'b0;
         respCode    <= `MPR_RSP_NORMAL;
         respValue   <= 8'h00;
         txFwdValid  <= 1'b0;
         txFwdBinary <= 1'b0;
         regApply    <= 1'b0;
         nvmStore    <= 1'b0;
         tempDiscard <= 1'b0;
         lqtAbort    <= 1'b0;
      end else begin
         respValid   <= 1'b0;
         txFwdValid  <= 1'b0;
         regApply    <= 1'b0;
         nvmStore    <= 1'b0;
         tempDiscard <= 1'b0;
         lqtAbort    <= 1'b0;
         commit_q    <= 1'b0;
         restore_q   <= 1'b0;
         if (busy_q) begin
            // answer on store done, or at the deadline at the latest
            rspCnt_q <= rspCnt_q + {{(`MPR_RSP_W-1){1'b0}}, 1'b1};
            if (nvmAck || (rspCnt_q == RSP_LAST)) begin
               busy_q    <= 1'b0;
               respValid <= 1'b1;
               respCode  <= `MPR_RSP_NORMAL;
            end
         end else if (frameErr_q) begin
            respValid <= 1'b1;
            respCode  <= `MPR_RSP_ERROR;
         end else if (go_q) begin
            respValid <= 1'b1;
            respCode  <= `MPR_RSP_ERROR;
            respValue <= 8'h00;
            case (name_q)
               `MPR_NM_RESET: begin
                  if (noArg) begin
                     respValid   <= 1'b0;
                     tempDiscard <= 1'b1;
                     if (lqtActive) begin
                        lqtAbort  <= 1'b1;
                        restore_q <= 1'b1;
                        respValid <= 1'b1;
                        respCode  <= `MPR_RSP_NORMAL;
                     end else begin
                        commit_q <= 1'b1;
                        regApply <= 1'b1;
                        nvmStore <= 1'b1;
                        busy_q   <= 1'b1;
                        rspCnt_q <= {`MPR_RSP_W{1'b0}};
                     end
                  end
               end
               `MPR_NM_STBY_REL: begin
                  if (noArg && lowPower) begin
                     lowPower <= 1'b0;
                     respCode <= `MPR_RSP_NORMAL;
                  end
               end
               `MPR_NM_STBY_ENT: begin
                  if (noArg && !lowPower) begin
                     lowPower <= 1'b1;
                     respCode <= `MPR_RSP_NORMAL;
                  end
               end
               `MPR_NM_EXT_TIME: begin
                  if (noArg) begin
                     respCode  <= `MPR_RSP_VALUE;
                     respValue <= extTime_q;
                  end else if (setArg && (argVal_q <= `MPR_EXT_MAX)) begin
                     extTime_q <= argVal_q[7:0];
                     respCode  <= `MPR_RSP_NORMAL;
                  end
               end
               `MPR_NM_STBY_TIME: begin
                  if (noArg) begin
                     respCode  <= `MPR_RSP_VALUE;
                     respValue <= stbyTime_q;
                  end else if (setArg && timeOk) begin
                     stbyTime_q <= argVal_q[7:0];
                     respCode   <= `MPR_RSP_NORMAL;
                  end
               end
               `MPR_NM_SLEEP_TIME: begin
                  if (noArg) begin
                     respCode  <= `MPR_RSP_VALUE;
                     respValue <= sleepTime_q;
                  end else if (setArg && timeOk) begin
                     sleepTime_q <= argVal_q[7:0];
                     respCode    <= `MPR_RSP_NORMAL;
                  end
               end
               `MPR_NM_RF_OFF: begin
                  if (noArg && rfOn_q) begin
                     rfOn_q   <= 1'b0;
                     respCode <= `MPR_RSP_NORMAL;
                  end
               end
               `MPR_NM_RF_ON: begin
                  if (noArg && !rfOn_q) begin
                     rfOn_q   <= 1'b1;
                     respCode <= `MPR_RSP_NORMAL;
                  end
               end
               `MPR_NM_TX_TEXT, `MPR_NM_TX_BIN: begin
                  // transmit path gives its own answer when rf is on
                  if (rfOn_q) begin
                     respValid   <= 1'b0;
                     txFwdValid  <= 1'b1;
                     txFwdBinary <= (name_q == `MPR_NM_TX_BIN);
                  end
               end
               default: respCode <= `MPR_RSP_ERROR;
            endcase
         end
      end
   end

   // ==================================================================
   // low-power standby sequence: standby, optional extended, sleep
   reg [7:0] unitCnt_q;
   reg [7:0] unitLimit;
   reg       unitTick;
   wire      extOk = (extTime_q != 8'h00) && !lastTxBroadcast && achkCfg_q[`MPR_ACHK_GROUP_BIT];

   always @* begin
      case (stbyPhase)
         S_STBY: begin
            unitLimit = stbyTime_q;
            unitTick  = tick10_q;
         end
         S_EXT: begin
            unitLimit = extTime_q;
            unitTick  = tick20_q;
         end
         S_SLEEP: begin
            unitLimit = sleepTime_q;
            unitTick  = sleepCfg_q[`MPR_SLEEP_BASE_BIT] ? tick100_q : tick10_q;
         end
         default: begin
            unitLimit = 8'h00;
            unitTick  = 1'b0;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         stbyPhase <= S_OFF;
         unitCnt_q <= 8'h00;
      end else if (!lowPower) begin
         stbyPhase <= S_OFF;
         unitCnt_q <= 8'h00;
      end else if (stbyPhase == S_OFF) begin
         stbyPhase <= S_STBY;
         unitCnt_q <= 8'h00;
      end else if (unitTick) begin
         if (unitCnt_q + 8'h01 >= unitLimit) begin
            unitCnt_q <= 8'h00;
            case (stbyPhase)
               S_STBY:  stbyPhase <= extOk ? S_EXT : S_SLEEP;
               S_EXT:   stbyPhase <= S_SLEEP;
               default: stbyPhase <= S_STBY;
            endcase
         end else begin
            unitCnt_q <= unitCnt_q + 8'h01;
         end
      end
   end

   // rf stays up in standby and extended phases, down only in sleep or when off
   always @(posedge core_clk) begin
      if (sys_rst) begin
         rfPower <= 1'b0;
      end else begin
         rfPower <= rfOn_q && !(lowPower && (stbyPhase == S_SLEEP));
      end
   end

endmodule

// ==== hdl/mpr_defs.vh ====
// Purpose: constants for the modem power and reset command interpreter
// Assumes: core_clk at 25 MHz; commands arrive as bytes from a uart on core_clk
// Notes:   shared numbers are named here; parser and standby state codes are local to the core
`ifndef MPR_DEFS_VH
`define MPR_DEFS_VH

// ==================================================================
// clock and timing
`define MPR_CLK_KHZ         25000
`define MPR_TICK_MS         10
`define MPR_RSP_MAX_MS      520
`define MPR_DEC_LAST        4'h9
`define MPR_TICK_W          18
`define MPR_RSP_W           24

// ==================================================================
// characters
`define MPR_CH_AT           8'h40
`define MPR_CH_CR           8'h0D
`define MPR_CH_LF           8'h0A
`define MPR_CH_D0           8'h30
`define MPR_CH_D9           8'h39

// ==================================================================
// command names, three ascii letters
`define MPR_NM_RESET        24'h525354
`define MPR_NM_STBY_REL     24'h504F46
`define MPR_NM_STBY_ENT     24'h504F4E
`define MPR_NM_EXT_TIME     24'h505445
`define MPR_NM_STBY_TIME    24'h50544E
`define MPR_NM_SLEEP_TIME   24'h505453
`define MPR_NM_RF_OFF       24'h524F46
`define MPR_NM_RF_ON        24'h524F4E
`define MPR_NM_TX_TEXT      24'h545854
`define MPR_NM_TX_BIN       24'h54424E

// ==================================================================
// setting ranges and reset values
`define MPR_EXT_MAX         10'h00F
`define MPR_TIME_MIN        10'h001
`define MPR_TIME_MAX        10'h0FF
`define MPR_ARG_DIGITS      2'h3
`define MPR_EXT_RST         8'h00
`define MPR_STBY_RST        8'h0A
`define MPR_SLEEP_RST       8'h0A

// ==================================================================
// response codes
`define MPR_RSP_NORMAL      2'h0
`define MPR_RSP_ERROR       2'h1
`define MPR_RSP_VALUE       2'h2

// ==================================================================
// register port map and fields
`define MPR_ADR_SLEEP_CFG   2'h0
`define MPR_ADR_ACHK_CFG    2'h1
`define MPR_ADR_SER_CFG     2'h2
`define MPR_ADR_STATUS      2'h3
`define MPR_SLEEP_BASE_BIT  1
`define MPR_ACHK_GROUP_BIT  0
`define MPR_SLEEP_CFG_RST   8'h00
`define MPR_ACHK_CFG_RST    8'h01
`define MPR_SER_CFG_RST     8'h00

`endif

// ==== tb/mpr_cmd_chk.sv ====
// Purpose: port checks on the command core
// Assumes: one clock, sys_rst synchronous active high
// Notes:   response bound follows the RSP_MAX_CYCLES handed in
module mpr_cmd_chk #(
   parameter RSP_MAX_CYCLES = 40
) (
   input wire       core_clk,
   input wire       sys_rst,
   input wire [7:0] rxData,
   input wire       rxValid,
   input wire       lastTxBroadcast,
   input wire       respValid,
   input wire [1:0] respCode,
   input wire       txFwdValid,
   input wire       txFwdBinary,
   input wire       regApply,
   input wire       nvmStore,
   input wire       tempDiscard,
   input wire       lqtAbort,
   input wire [7:0] serialCfg,
   input wire       rfPower,
   input wire       lowPower,
   input wire [1:0] stbyPhase
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RspWin = RSP_MAX_CYCLES + 1;
   logic [7:0] prevByte_q;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // ==========================================
   // last byte seen, to spot a bare line feed
   always @(posedge core_clk) begin
      if (sys_rst)
         prevByte_q <= 8'h00;
      else if (rxValid)
         prevByte_q <= rxData;
   end
   // ==========================================
   // assertions
   chk_commit_trio: assert property (regApply |-> nvmStore && tempDiscard)
      else $error("commit pulses apart");
   chk_rsp_bound: assert property (nvmStore |-> ##[1:RspWin] respValid && respCode == 2'h0)
      else $error("reset answer too late");
   chk_lqt_exit: assert property (lqtAbort |-> tempDiscard && !regApply && respValid && respCode == 2'h0)
      else $error("line test exit wrong");
   chk_ser_commit: assert property ($changed(serialCfg) |-> $past(regApply))
      else $error("serial cfg moved without commit");
   chk_fwd_rf: assert property (txFwdValid |-> rfPower && !respValid)
      else $error("transmit forwarded badly");
   chk_enter_phase: assert property ($rose(lowPower) |=> stbyPhase == 2'h1)
      else $error("standby phase not started");
   chk_leave_phase: assert property ($fell(lowPower) |=> stbyPhase == 2'h0)
      else $error("standby phase not cleared");
   chk_ext_bcast: assert property ($rose(stbyPhase == 2'h2) |-> !$past(lastTxBroadcast))
      else $error("extended after broadcast");
   chk_frame_lf: assert property (rxValid && rxData == 8'h0A && prevByte_q != 8'h0D
      |-> ##2 respValid && respCode == 2'h1)
      else $error("bare line feed not refused");
   // main scenarios reached
   cov_store: cover property (nvmStore);
   cov_lqt: cover property (lqtAbort);
   cov_ext: cover property (stbyPhase == 2'h2);
   cov_bin: cover property (txFwdValid && txFwdBinary);
endmodule

bind mpr_cmd_core mpr_cmd_chk #(.RSP_MAX_CYCLES(RSP_MAX_CYCLES)) u_mpr_cmd_chk (.core_clk, .sys_rst, .rxData,
   .rxValid, .lastTxBroadcast, .respValid, .respCode, .txFwdValid, .txFwdBinary, .regApply, .nvmStore,
   .tempDiscard, .lqtAbort, .serialCfg, .rfPower, .lowPower, .stbyPhase);

// ==== tb/mpr_host_model.sv ====
// Purpose: host side of the command link, sends framed text commands
// Assumes: one byte per rxValid pulse on core_clk
// Notes:   idle data lines show the inverse of the last byte
module mpr_host_model (
   input  wire        core_clk,
   output logic [7:0] rxData,
   output logic       rxValid
);
   timeunit 1ns;
   timeprecision 1ps;
   // quiet line at time zero
   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
   end
   // gap idle cycles between bytes, none after the last so the caller sees the answer pulse
   task automatic send(input string s, input int gap);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge core_clk);
         rxData <= s[i];
         rxValid <= 1'b1;
         repeat (i + 1 < s.len() ? gap : 0) begin
            @(posedge core_clk);
            rxValid <= 1'b0;
            rxData <= ~s[i];
         end
      end
      @(posedge core_clk);
      rxValid <= 1'b0;
      rxData <= ~rxData;
   endtask
   // frame marker first, carriage return then line feed last
   task automatic cmd(input string b, input int gap);
      send({"@", b, "\r\n"}, gap);
   endtask
endmodule

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the command core
// Assumes: short tick and answer limits through parameters
// Notes:   nvmAck follows store pulses unless ackEn is low
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] regWrData = 8'h00;
   logic       regWr = 1'b0;
   logic       regRd = 1'b0;
   logic       nvmAck = 1'b0;
   logic       ackEn = 1'b1;
   logic       lqtActive = 1'b0;
   logic       lastTxBroadcast = 1'b0;
   logic       saw;
   wire  [7:0] rxData, regRdData, respValue, serialCfg;
   wire  [1:0] respCode, stbyPhase;
   wire        rxValid, respValid, txFwdValid, txFwdBinary;
   wire        regApply, nvmStore, tempDiscard, lqtAbort, rfPower, lowPower;
   int         n_mismatch = 0;
   int         checks_done = 0;
   int         cyc = 0;
   int         n3;
   localparam int NC = 22;
   // commands and expected {code, value}; code 3 means forwarded; first letters as octal escapes except in RON and XYZ
   string      cmds [NC] = '{"\120TE", "\120TE015", "\120TE016", "\120TE01", "\120TE", "\120TN000",
      "\120TN255", "\120TN", "\120TS256", "\120TS", "\120ON", "\120ON", "\120OF", "\120OF", "\122OF",
      "\122OF", "\124XT", "\124BN", "RON", "\124XT", "\124BN", "XYZ"};
   logic [9:0] exps [NC] = '{10'h200, 10'h000, 10'h100, 10'h100, 10'h20F, 10'h100, 10'h000, 10'h2FF, 10'h100,
      10'h20A, 10'h000, 10'h100, 10'h000, 10'h100, 10'h000, 10'h100, 10'h100, 10'h100, 10'h000, 10'h300,
      10'h301, 10'h100};

   mpr_cmd_core #(.TICK10_CYCLES(8), .RSP_MAX_CYCLES(40)) u_mpr_cmd_core (.core_clk, .sys_rst, .rxData,
      .rxValid, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .nvmAck, .lqtActive, .lastTxBroadcast,
      .respValid, .respCode, .respValue, .txFwdValid, .txFwdBinary, .regApply, .nvmStore, .tempDiscard,
      .lqtAbort, .serialCfg, .rfPower, .lowPower, .stbyPhase);
   mpr_host_model u_mpr_host_model (.core_clk, .rxData, .rxValid);

   // ==========================================
   // clock, store acknowledge and hang guard
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) nvmAck <= nvmStore & ackEn;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_mismatch++;
         stop_test();
      end
   end
   // ==========================================
   // tasks
   task automatic stop_test;
      $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait for an answer or a forward, then compare
   task automatic expect_rsp(input logic [9:0] e);
      repeat (80) begin
         @(posedge core_clk);
         #1;
         if (respValid === 1'b1 || txFwdValid === 1'b1) break;
      end
      if (e[9:8] == 2'h3) begin
         chk({6'h00, txFwdValid, respValid}, 8'h02);
         chk({7'h00, txFwdBinary}, e[7:0]);
      end else begin
         chk({6'h00, txFwdValid, respValid}, 8'h01);
         chk({6'h00, respCode}, {6'h00, e[9:8]});
         chk(respValue, e[7:0]);
      end
   endtask
   task automatic run(input string s, input logic [9:0] e);
      u_mpr_host_model.cmd(s, 0);
      expect_rsp(e);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      chk(regRdData, e);
   endtask
   // one standby round; counts sleep cycles, notes any extended phase
   task automatic run_stby(input logic expExt);
      run("\120ON", 10'h000);
      saw = 1'b0;
      n3 = 0;
      repeat (400) begin
         @(posedge core_clk);
         #1;
         if (stbyPhase === 2'h2) saw = 1'b1;
         if (stbyPhase === 2'h3) n3++;
         else if (n3 != 0) break;
      end
      chk({7'h00, saw}, {7'h00, expExt});
      run("\120OF", 10'h000);
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < NC; i++) begin
         u_mpr_host_model.cmd(cmds[i], i % 3);
         expect_rsp(exps[i]);
      end
      u_mpr_host_model.send("@\120TE\n", 0);
      expect_rsp(10'h100);
      u_mpr_host_model.send("@\120TE\rA", 0);
      expect_rsp(10'h100);
      // status is read only; staged values wait for the reset command
      wr(2'h3, 8'hFF);
      rd(2'h3, 8'h01);
      wr(2'h1, 8'h00);
      wr(2'h2, 8'h5A);
      rd(2'h1, 8'h00);
      chk(serialCfg, 8'h00);
      run("RST", 10'h000);
      chk(serialCfg, 8'h5A);
      rd(2'h2, 8'h5A);
      ackEn <= 1'b0;
      run("RST", 10'h000);
      ackEn <= 1'b1;
      // reset inside the line test drops the staged write
      @(posedge core_clk) lqtActive <= 1'b1;
      wr(2'h0, 8'h02);
      run("RST", 10'h000);
      @(posedge core_clk) lqtActive <= 1'b0;
      rd(2'h0, 8'h00);
      // standby rounds: extended, broadcast, group check off, zero, long base
      wr(2'h1, 8'h01);
      run("RST", 10'h000);
      run("\120TN001", 10'h000);
      run("\120TE001", 10'h000);
      run("\120TS002", 10'h000);
      run_stby(1'b1);
      chk({7'h00, n3 <= 17}, 8'h01);
      @(posedge core_clk) lastTxBroadcast <= 1'b1;
      run_stby(1'b0);
      @(posedge core_clk) lastTxBroadcast <= 1'b0;
      wr(2'h1, 8'h00);
      run("RST", 10'h000);
      run_stby(1'b0);
      wr(2'h0, 8'h02);
      wr(2'h1, 8'h01);
      run("RST", 10'h000);
      run("\120TE000", 10'h000);
      run_stby(1'b0);
      chk({7'h00, n3 >= 80}, 8'h01);
      stop_test();
   end
endmodule
